// File: drive_word_map.vh
// Constants for the drive control and status word logic
// Summary of operation
// - Velocity: bit4 ramp enable, bit5 unfreeze
// - Velocity: bit6 enables setpoint, else decelerate
// - Velocity: bits 8, 9, 11 ignored
// - Torque: bits 4-6, 9, 11 held zero; any set drives reserved_bits_error_r
// - Torque: bit8 set halts the axis
// - Status bits follow sources, captured on each cyclic update and held between updates
// - Status bit4 low on coast stop
// - Status bit5 low on quick stop or safety
// - Status bit9 set when control word processed
// - Bit10 follows target reached even in fault
// - Bit14 high on base block or safety
// - Bit14 source chosen by safety card presence
// - Bits 0-3, 6 encode drive state
// - Bit7 set on any warning
// - Limit flag on bit15 position, else bit11
`ifndef DRIVE_WORD_MAP_VH
`define DRIVE_WORD_MAP_VH
`define CTRL_WORD_INDEX 16'h6040
`define STAT_WORD_INDEX 16'h6041
`define CW_RAMP_EN 4
`define CW_UNFREEZE 5
`define CW_SETPOINT 6
`define CW_HALT 8
`define SW_COAST 4
`define SW_QSTOP 5
`define SW_INHIBIT 6
`define SW_WARN 7
`define SW_CTRL_REQ 9
`define SW_TARGET 10
`define SW_LIMIT_OTHER 11
`define SW_SAFETY 14
`define SW_LIMIT_POS 15
`define MODE_POSITION 2'h0
`define MODE_VELOCITY 2'h1
`define MODE_TORQUE 2'h2
`define ST_NOT_READY 3'h0
`define ST_INHIBITED 3'h1
`define ST_READY 3'h2
`define ST_SWITCHED_ON 3'h3
`define ST_OPERATION 3'h4
`define ST_STOPPING 3'h5
`define ST_FAULT_REACT 3'h6
`define ST_FAULT 3'h7
`define HALT_CODE_STD 3'h3
`define STATUS_RESET 16'h0000
`endif

// File: status_state_encoder.v
// State-bit encoder for the drive status word
`timescale 1ns/10ps
`include "drive_word_map.vh"
module status_state_encoder
(
	// Drive state
	input wire [2:0] drive_state,
	// Bits 0,1,2,3,6 as {b6,b3,b2,b1,b0}
	output reg [4:0] state_bits
);
always @*
begin
	case (drive_state)
		`ST_NOT_READY: state_bits = 5'h00;
		`ST_INHIBITED: state_bits = 5'h10;
		`ST_READY: state_bits = 5'h01;
		`ST_SWITCHED_ON: state_bits = 5'h03;
		`ST_OPERATION: state_bits = 5'h07;
		`ST_STOPPING: state_bits = 5'h03;
		`ST_FAULT_REACT: state_bits = 5'h0F;
		`ST_FAULT: state_bits = 5'h18;
		default: state_bits = 5'h00;
	endcase
end
endmodule

// File: drive_control_status_word_logic.v
// Control word decoder and status word composer
`timescale 1ns/10ps
`include "drive_word_map.vh"
module drive_control_status_word_logic
(
	// Clock and reset
	input wire sys_clk,
	input wire reset_n,
	// Cyclic process data
	input wire [15:0] drive_control_word,
	input wire control_word_valid,
	input wire cyclic_update,
	output reg [15:0] drive_status_word,
	// Mode and drive state
	input wire [1:0] op_mode,
	input wire [2:0] drive_state,
	input wire drive_ready,
	// Stop and safety sources
	input wire coast_stop_request,
	input wire quick_stop_request,
	input wire safety_stop_request,
	input wire hardwired_base_block,
	input wire safety_card_fitted,
	input wire [2:0] safety_state_bits,
	// Other status sources
	input wire warning_active,
	input wire target_reached,
	input wire internal_limit_active,
	input wire mode_bit8,
	input wire [1:0] mode_bits_12_13,
	input wire pos_home_valid,
	// Ramp and stop controls
	output reg ramp_enable_r,
	output reg ramp_unfreeze_r,
	output reg setpoint_enable_r,
	output reg halt_option_stop_r,
	output reg profile_decel_stop_r,
	output reg reserved_bits_error_r
);
wire [4:0] state_bits;
reg [15:0] status_nxt;
reg ramp_enable_nxt;
reg ramp_unfreeze_nxt;
reg setpoint_enable_nxt;
reg halt_stop_nxt;
reg decel_stop_nxt;
reg resv_err_nxt;
reg [15:0] cw_r;

status_state_encoder u_state
(
	.drive_state(drive_state),
	.state_bits(state_bits)
);

// Latest accepted control word
always @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
		cw_r <= 16'h0000;
	else if (control_word_valid)
		cw_r <= drive_control_word;
end

always @*
begin
	ramp_enable_nxt = 1'b0;
	ramp_unfreeze_nxt = 1'b0;
	setpoint_enable_nxt = 1'b0;
	halt_stop_nxt = 1'b0;
	decel_stop_nxt = 1'b0;
	resv_err_nxt = 1'b0;
	case (op_mode)
		`MODE_VELOCITY:
		begin
			// Bits 8, 9 and 11 are not looked at in this mode
			ramp_enable_nxt = cw_r[`CW_RAMP_EN];
			halt_stop_nxt = ~cw_r[`CW_RAMP_EN];
			ramp_unfreeze_nxt = cw_r[`CW_UNFREEZE];
			setpoint_enable_nxt = cw_r[`CW_SETPOINT];
			decel_stop_nxt = ~cw_r[`CW_SETPOINT];
		end
		`MODE_TORQUE:
		begin
			ramp_enable_nxt = 1'b1;
			ramp_unfreeze_nxt = 1'b1;
			setpoint_enable_nxt = ~cw_r[`CW_HALT];
			halt_stop_nxt = cw_r[`CW_HALT];
			resv_err_nxt = |{cw_r[11], cw_r[9], cw_r[6:4]};
		end
		default:
		begin
			ramp_enable_nxt = 1'b0;
		end
	endcase
end

always @*
begin
	status_nxt = 16'h0000;
	{status_nxt[6], status_nxt[3:0]} = state_bits;
	status_nxt[`SW_COAST] = ~coast_stop_request;
	status_nxt[`SW_QSTOP] = ~(quick_stop_request | safety_stop_request);
	status_nxt[`SW_WARN] = warning_active;
	status_nxt[8] = mode_bit8;
	status_nxt[`SW_CTRL_REQ] = drive_ready & control_word_valid;
	status_nxt[`SW_TARGET] = target_reached;
	status_nxt[13:12] = mode_bits_12_13;
	if (safety_card_fitted)
		status_nxt[`SW_SAFETY] = |safety_state_bits;
	else
		status_nxt[`SW_SAFETY] = hardwired_base_block;
	if (op_mode == `MODE_POSITION)
	begin
		status_nxt[`SW_LIMIT_POS] = internal_limit_active;
		status_nxt[`SW_LIMIT_OTHER] = pos_home_valid;
	end
	else
		status_nxt[`SW_LIMIT_OTHER] = internal_limit_active;
end

// Outputs are registered; status captured on every cyclic update
always @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		drive_status_word <= `STATUS_RESET;
		ramp_enable_r <= 1'b0;
		ramp_unfreeze_r <= 1'b0;
		setpoint_enable_r <= 1'b0;
		halt_option_stop_r <= 1'b0;
		profile_decel_stop_r <= 1'b0;
		reserved_bits_error_r <= 1'b0;
	end
	else
	begin
		if (cyclic_update)
			drive_status_word <= status_nxt;
		ramp_enable_r <= ramp_enable_nxt;
		ramp_unfreeze_r <= ramp_unfreeze_nxt;
		setpoint_enable_r <= setpoint_enable_nxt;
		halt_option_stop_r <= halt_stop_nxt;
		profile_decel_stop_r <= decel_stop_nxt;
		reserved_bits_error_r <= resv_err_nxt;
	end
end
endmodule

// File: drive_word_checker_assertions.sv
// Checker for the drive status word
`timescale 1ns/10ps
module drive_word_checker
(
	// Watched ports
	input wire sys_clk,
	input wire reset_n,
	input wire control_word_valid,
	input wire cyclic_update,
	input wire [15:0] drive_status_word,
	input wire [1:0] op_mode,
	input wire drive_ready,
	input wire coast_stop_request,
	input wire quick_stop_request,
	input wire safety_stop_request,
	input wire hardwired_base_block,
	input wire safety_card_fitted,
	input wire [2:0] safety_state_bits,
	input wire warning_active,
	input wire target_reached,
	input wire internal_limit_active
);
wire [15:0] s = drive_status_word;
default clocking @(posedge sys_clk); endclocking
default disable iff (!reset_n);
a_coast_bit: assert property (cyclic_update |=> s[4] == !$past(coast_stop_request))
	else $error("bit 4");
a_quick_bit: assert property (cyclic_update |=> s[5] == !($past(quick_stop_request) | $past(safety_stop_request)))
	else $error("bit 5");
a_warn_bit: assert property (cyclic_update |=> s[7] == $past(warning_active))
	else $error("bit 7");
a_ctrl_req: assert property (cyclic_update |=> s[9] == ($past(drive_ready) & $past(control_word_valid)))
	else $error("bit 9");
a_target_bit: assert property (cyclic_update |=> s[10] == $past(target_reached))
	else $error("bit 10");
a_safety_bit: assert property (cyclic_update |=> s[14] ==
	($past(safety_card_fitted) ? |$past(safety_state_bits) : $past(hardwired_base_block)))
	else $error("bit 14");
a_limit_bit: assert property (cyclic_update |=> s[15] == ($past(op_mode) == 2'h0 && $past(internal_limit_active)))
	else $error("bit 15");
a_limit_other: assert property (cyclic_update && op_mode != 2'h0 |=> s[11] == $past(internal_limit_active))
	else $error("bit 11");
a_status_hold: assert property (!cyclic_update |=> $stable(s))
	else $error("status moved");
endmodule
bind drive_control_status_word_logic drive_word_checker chk_i (.*);

// File: fieldbus_ctrl_model.sv
// Fieldbus controller model for cyclic process data
`timescale 1ns/10ps
module fieldbus_ctrl_model
(
	// Process data
	input wire sys_clk,
	output reg [15:0] drive_control_word,
	output reg control_word_valid,
	output reg cyclic_update
);
// Halt option code the controller configures for standard stopping
localparam [2:0] HALT_OPTION_CODE = 3'h3;
initial {drive_control_word, control_word_valid, cyclic_update} = 18'h00000;
task send(input [15:0] w);
begin
	drive_control_word = w;
	control_word_valid = 1'b1;
	@(posedge sys_clk) #1;
	control_word_valid = 1'b0;
	drive_control_word = ~w;
end
endtask
task update;
begin
	cyclic_update = 1'b1;
	@(posedge sys_clk) #1;
	cyclic_update = 1'b0;
end
endtask
endmodule

// File: drive_control_status_word_logic_tb.sv
// Bench for the drive control and status word block
`timescale 1ns/10ps
module drive_control_status_word_logic_tb;
logic sys_clk = 0, reset_n = 0, drive_ready, coast_stop_request, quick_stop_request, safety_stop_request;
logic hardwired_base_block, safety_card_fitted, warning_active, target_reached, internal_limit_active;
logic mode_bit8, pos_home_valid;
logic [1:0] op_mode, mode_bits_12_13;
logic [2:0] drive_state, safety_state_bits;
wire [15:0] drive_control_word, drive_status_word;
wire control_word_valid, cyclic_update, ramp_enable_r, ramp_unfreeze_r, setpoint_enable_r;
wire halt_option_stop_r, profile_decel_stop_r, reserved_bits_error_r;
wire [5:0] ctl = {ramp_enable_r, ramp_unfreeze_r, setpoint_enable_r, halt_option_stop_r,
	profile_decel_stop_r, reserved_bits_error_r};
int errors = 0, comparisons = 0;
always #20 sys_clk = ~sys_clk;
drive_control_status_word_logic dut (.*);
fieldbus_ctrl_model fb (.*);
task chk(input string n, input [15:0] g, input [15:0] e);
begin
	comparisons++;
	if (g !== e)
	begin
		errors++;
		$display("FAIL %s exp %h got %h", n, e, g);
	end
end
endtask
task st(input [20:0] v);
	{op_mode, drive_state, drive_ready, coast_stop_request, quick_stop_request, safety_stop_request,
		hardwired_base_block, safety_card_fitted, safety_state_bits, warning_active, target_reached,
		internal_limit_active, mode_bit8, mode_bits_12_13, pos_home_valid} = v;
endtask
task cw(input [15:0] w, input [15:0] e);
begin
	fb.send(w);
	@(posedge sys_clk) #1;
	chk("ctl", {10'h000, ctl}, e);
end
endtask
task sw(input [20:0] v, input [15:0] e);
begin
	@(posedge sys_clk) #1;
	st(v);
	fork
		fb.send(16'h0000);
		fb.update;
	join
	chk("status", drive_status_word, e);
end
endtask
task stop_test;
begin
	$display("errors %0d comparisons %0d", errors, comparisons);
	if (errors == 0 && comparisons > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
end
endtask
initial
begin
	#20000;
	errors++;
	stop_test;
end
initial
begin
	st(21'h000000);
	repeat (3) @(posedge sys_clk);
	#1 reset_n = 1;
	st(21'h080000);
	cw(16'h0070, 16'h0038);
	cw(16'h0B20, 16'h0016);
	st(21'h100000);
	cw(16'h0100, 16'h0034);
	cw(16'h0010, 16'h0039);
	sw(21'h0C5830, 16'h4C07);
	sw(21'h072570, 16'hC4D8);
	sw(21'h118C0E, 16'h3370);
	stop_test;
end
endmodule
